// file: tap_decoder_pkg.sv
// shared constants and types of the test access port instruction decoder
package tap_decoder_pkg;

  // instruction register
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_CAPTURE_PATTERN = 4'h1;
  localparam logic [3:0] INSN_EXT_TEST = 4'h0;
  localparam logic [3:0] INSN_INT_TEST = 4'h1;
  localparam logic [3:0] INSN_SAMPLE_PRELOAD = 4'h2;
  localparam logic [3:0] INSN_DP_ABORT = 4'h8;
  localparam logic [3:0] INSN_DP_ACCESS = 4'hA;
  localparam logic [3:0] INSN_AP_ACCESS = 4'hB;
  localparam logic [3:0] INSN_IDENT = 4'hE;
  localparam logic [3:0] INSN_BYPASS = 4'hF;

  // identification word; value is arbitrary, bit 0 must stay 1
  localparam logic [31:0] IDENT_VALUE = 32'h0A5C_0001;

  // data chain lengths
  localparam int NUM_PADS = 8;
  localparam int BOUNDARY_LEN = 3 * NUM_PADS + 1;
  localparam int IDENT_LEN = 32;
  localparam int DAP_LEN = 35;
  localparam int DR_MAX = 35;
  localparam logic [5:0] LEN_BYPASS = 6'h01;
  localparam logic [5:0] LEN_IDENT = 6'h20;
  localparam logic [5:0] LEN_DAP = 6'h23;
  localparam logic [5:0] LEN_BOUNDARY = 6'h19;

  // boundary cell positions within one pad's group, and the reset cell
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int CELL_RESET = 3 * NUM_PADS;

  // test-port pin function select: five pins, all alternate after reset
  localparam int PORT_PINS = 5;
  localparam logic [4:0] PIN_AF_RESET = 5'h1F;

  // debug access chain selector codes
  localparam logic [1:0] DAP_SEL_ABORT = 2'h0;
  localparam logic [1:0] DAP_SEL_DP = 2'h1;
  localparam logic [1:0] DAP_SEL_AP = 2'h2;

  // bit positions of the raw input vector that passes the synchroniser
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TRST_N = 3;
  localparam int PIN_EXT_RST_N = 4;
  localparam int PIN_PADS = 5;
  localparam int SYNC_WIDTH = PIN_PADS + NUM_PADS;

  // test access port controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } tap_state_type;

  // which data chain sits between serial input and output
  typedef enum logic [4:0] {
    CHAIN_BYPASS   = 5'h01,
    CHAIN_IDENT    = 5'h02,
    CHAIN_BOUNDARY = 5'h04,
    CHAIN_DAP      = 5'h08,
    CHAIN_NONE     = 5'h10
  } chain_type;

endpackage : tap_decoder_pkg

// file: tap_instruction_decoder.sv
// instruction register, decode and data chains of the four-bit test access port
//
// Summary of operation
// - four-bit instruction chain with parallel holding register
// - code 0000 drives pads from preload
// - code 0001 feeds core inputs from preload
// - code 0010 selects boundary chain, captures pads
// - shift-data moves samples out, preload in
// - update-data copies boundary chain into holding
// - boundary chain stays accessible during both tests
// - reset cell observed only, never driven
// - code 1000 selects debug abort chain
// - code 1010 selects debug port access chain
// - code 1011 selects access port chain
// - code 1110 selects identification chain
// - identification loaded on every reset path
// - code 1111 selects one-bit bypass
// - unassigned codes behave as bypass
// - all chains reachable serially, no bus
// - test-port pins default to test function
// - identification 32 bits, LSB one; bypass zero
// - debug chains are 35 bits long
// - three cells per pin, in/out/enable order
`timescale 1ns/1ps
module tap_instruction_decoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_q,
  output logic tdo_oe_q,
  // external reset pin, observed by the boundary chain
  input wire logic ext_rst_n,
  output logic core_ext_rst_n_q,
  // pads and core
  input wire logic [tap_decoder_pkg::NUM_PADS-1:0] pad_in,
  output logic [tap_decoder_pkg::NUM_PADS-1:0] pad_out_q,
  output logic [tap_decoder_pkg::NUM_PADS-1:0] pad_oe_q,
  input wire logic [tap_decoder_pkg::NUM_PADS-1:0] core_pad_out,
  input wire logic [tap_decoder_pkg::NUM_PADS-1:0] core_pad_oe,
  output logic [tap_decoder_pkg::NUM_PADS-1:0] core_pad_in_q,
  // debug access unit
  input wire logic [tap_decoder_pkg::DAP_LEN-1:0] dap_capture_data,
  output logic [tap_decoder_pkg::DAP_LEN-1:0] dap_wr_data_q,
  output logic [1:0] dap_sel_q,
  output logic dap_wr_strobe_q,
  // test-port pin function select
  input wire logic [tap_decoder_pkg::PORT_PINS-1:0] sw_gpio_request,
  output logic [tap_decoder_pkg::PORT_PINS-1:0] pin_alternate_function_select_q,
  // active instruction, for observation
  output logic [tap_decoder_pkg::IR_WIDTH-1:0] instruction_register_q
);
  import tap_decoder_pkg::*;

  logic [SYNC_WIDTH-1:0] raw_in;
  logic [SYNC_WIDTH-1:0] sync1_q;
  logic [SYNC_WIDTH-1:0] sync2_q;
  logic tck_last_q;
  logic tck_rise;
  logic tck_fall;
  logic trst;
  logic tms_s;
  logic tdi_s;
  logic [NUM_PADS-1:0] pad_in_s;
  tap_state_type state_q;
  logic [IR_WIDTH-1:0] ir_shift_q;
  chain_type chain;
  logic [5:0] chain_len;
  logic [DR_MAX-1:0] dr_shift_q;
  logic [BOUNDARY_LEN-1:0] bsr_capture;
  logic [BOUNDARY_LEN-1:0] bsr_hold_q;
  logic ext_test;
  logic int_test;

  // map an instruction code onto the data chain it selects
  function automatic chain_type decode_chain(input logic [IR_WIDTH-1:0] insn);
    chain_type c;
    c = CHAIN_BYPASS;
    case (insn)
      INSN_EXT_TEST: c = CHAIN_BOUNDARY;
      INSN_INT_TEST: c = CHAIN_BOUNDARY;
      INSN_SAMPLE_PRELOAD: c = CHAIN_BOUNDARY;
      INSN_DP_ABORT: c = CHAIN_DAP;
      INSN_DP_ACCESS: c = CHAIN_DAP;
      INSN_AP_ACCESS: c = CHAIN_DAP;
      INSN_IDENT: c = CHAIN_IDENT;
      INSN_BYPASS: c = CHAIN_BYPASS;
      default: c = CHAIN_BYPASS;
    endcase
    return c;
  endfunction : decode_chain

  // length in cells of each chain
  function automatic logic [5:0] length_of(input chain_type c);
    logic [5:0] n;
    n = LEN_BYPASS;
    case (c)
      CHAIN_IDENT: n = LEN_IDENT;
      CHAIN_BOUNDARY: n = LEN_BOUNDARY;
      CHAIN_DAP: n = LEN_DAP;
      default: n = LEN_BYPASS;
    endcase
    return n;
  endfunction : length_of

  // shift one bit toward the output end; the new bit enters at the chain's far end
  function automatic logic [DR_MAX-1:0] shift_chain(input logic [DR_MAX-1:0] cur,
                                                    input logic [5:0] len,
                                                    input logic din);
    logic [DR_MAX-1:0] res;
    res = cur >> 1;
    for (int i = 0; i < DR_MAX; i++) begin
      if (i == int'(len) - 1) begin
        res[i] = din;
      end else if (i >= int'(len)) begin
        res[i] = 1'b0;
      end
    end
    return res;
  endfunction : shift_chain

  // every pin from outside passes two flops before anything looks at it
  assign raw_in = {pad_in, ext_rst_n, trst_n, tdi, tms, tck};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // edge finder on the synchronised test clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_last_q <= 1'b0;
    end else begin
      tck_last_q <= sync2_q[PIN_TCK];
    end
  end

  assign tck_rise = sync2_q[PIN_TCK] & ~tck_last_q;
  assign tck_fall = ~sync2_q[PIN_TCK] & tck_last_q;
  // sync flops reset low, so the test reset pin reads asserted for two cycles
  assign trst = ~sync2_q[PIN_TRST_N];
  assign tms_s = sync2_q[PIN_TMS];
  assign tdi_s = sync2_q[PIN_TDI];
  assign pad_in_s = sync2_q[PIN_PADS +: NUM_PADS];

  tap_state_tracker u_state (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tms(tms_s),
    .trst(trst),
    .state_q(state_q)
  );

  // instruction shift chain: fixed pattern on capture, lsb first on shift
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ir_shift_q <= IR_CAPTURE_PATTERN;
    end else if (tck_rise) begin
      if (state_q == TAP_CAPTURE_IR) begin
        ir_shift_q <= IR_CAPTURE_PATTERN;
      end else if (state_q == TAP_SHIFT_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
      end
    end
  end

  // active instruction changes only on update; every reset path loads identification
  always_ff @(posedge ref_clk) begin
    if (sys_rst || trst || state_q == TAP_RESET) begin
      instruction_register_q <= INSN_IDENT;
    end else if (tck_rise && state_q == TAP_UPDATE_IR) begin
      instruction_register_q <= ir_shift_q;
    end
  end

  assign chain = decode_chain(instruction_register_q);
  assign chain_len = length_of(chain);
  assign ext_test = (instruction_register_q == INSN_EXT_TEST);
  assign int_test = (instruction_register_q == INSN_INT_TEST);

  // boundary sample: input, output, enable per pad, nearest pad first, reset cell last
  generate
    for (genvar p = 0; p < NUM_PADS; p++) begin : g_cells
      assign bsr_capture[3*p+CELL_IN] = pad_in_s[p];
      assign bsr_capture[3*p+CELL_OUT] = pad_out_q[p];
      assign bsr_capture[3*p+CELL_OE] = pad_oe_q[p];
    end
  endgenerate
  assign bsr_capture[CELL_RESET] = sync2_q[PIN_EXT_RST_N];

  // data shift chain shared by all data registers; only the serial port reaches it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dr_shift_q <= '0;
    end else if (tck_rise) begin
      if (state_q == TAP_CAPTURE_DR) begin
        case (chain)
          CHAIN_IDENT: dr_shift_q <= {{(DR_MAX-IDENT_LEN){1'b0}}, IDENT_VALUE};
          CHAIN_BOUNDARY: dr_shift_q <= {{(DR_MAX-BOUNDARY_LEN){1'b0}}, bsr_capture};
          CHAIN_DAP: dr_shift_q <= dap_capture_data;
          default: dr_shift_q <= '0; // bypass captures zero
        endcase
      end else if (state_q == TAP_SHIFT_DR) begin
        dr_shift_q <= shift_chain(dr_shift_q, chain_len, tdi_s);
      end
    end
  end

  // boundary holding register, written on update under any boundary instruction
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bsr_hold_q <= '0;
    end else if (tck_rise && state_q == TAP_UPDATE_DR && chain == CHAIN_BOUNDARY) begin
      bsr_hold_q <= dr_shift_q[BOUNDARY_LEN-1:0];
    end
  end

  // pad drive: preload replaces core values under external test
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
    end else begin
      for (int p = 0; p < NUM_PADS; p++) begin
        pad_out_q[p] <= ext_test ? bsr_hold_q[3*p+CELL_OUT] : core_pad_out[p];
        pad_oe_q[p] <= ext_test ? bsr_hold_q[3*p+CELL_OE] : core_pad_oe[p];
      end
    end
  end

  // core inputs: preload replaces pads under internal test
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_pad_in_q <= '0;
    end else begin
      for (int p = 0; p < NUM_PADS; p++) begin
        core_pad_in_q[p] <= int_test ? bsr_hold_q[3*p+CELL_IN] : pad_in_s[p];
      end
    end
  end

  // core reset follows the pin only; the preloaded reset cell is never used
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_ext_rst_n_q <= 1'b0;
    end else begin
      core_ext_rst_n_q <= sync2_q[PIN_EXT_RST_N];
    end
  end

  // debug access unit write: one-cycle strobe on update of any debug chain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dap_wr_strobe_q <= 1'b0;
      dap_wr_data_q <= '0;
      dap_sel_q <= DAP_SEL_ABORT;
    end else begin
      dap_wr_strobe_q <= 1'b0;
      if (tck_rise && state_q == TAP_UPDATE_DR && chain == CHAIN_DAP) begin
        dap_wr_strobe_q <= 1'b1;
        dap_wr_data_q <= dr_shift_q[DAP_LEN-1:0];
        case (instruction_register_q)
          INSN_DP_ACCESS: dap_sel_q <= DAP_SEL_DP;
          INSN_AP_ACCESS: dap_sel_q <= DAP_SEL_AP;
          default: dap_sel_q <= DAP_SEL_ABORT;
        endcase
      end
    end
  end

  // serial output changes on the falling test clock, enabled only while shifting
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      if (state_q == TAP_SHIFT_IR) begin
        tdo_q <= ir_shift_q[0];
        tdo_oe_q <= 1'b1;
      end else if (state_q == TAP_SHIFT_DR) begin
        tdo_q <= dr_shift_q[0];
        tdo_oe_q <= 1'b1;
      end else begin
        tdo_q <= 1'b0;
        tdo_oe_q <= 1'b0;
      end
    end
  end

  // pins come up in their test function after a system or external pin reset; software may hand them
  // over later and must hand them back before a probe can talk again
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !sync2_q[PIN_EXT_RST_N]) begin
      pin_alternate_function_select_q <= PIN_AF_RESET;
    end else begin
      pin_alternate_function_select_q <= ~sw_gpio_request;
    end
  end

endmodule : tap_instruction_decoder

// file: tap_instruction_decoder_asserts.sv
// assertions on the ports of the test access port instruction decoder
`timescale 1ns/1ps
module tap_instruction_decoder_asserts
  import tap_decoder_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pins
  input wire logic tck,
  input wire logic trst_n,
  input wire logic ext_rst_n,
  input wire logic core_ext_rst_n_q,
  // pads
  input wire logic [NUM_PADS-1:0] core_pad_out,
  input wire logic [NUM_PADS-1:0] core_pad_oe,
  input wire logic [NUM_PADS-1:0] pad_out_q,
  input wire logic [NUM_PADS-1:0] pad_oe_q,
  // debug access and pin select
  input wire logic [DAP_LEN-1:0] dap_wr_data_q,
  input wire logic [1:0] dap_sel_q,
  input wire logic dap_wr_strobe_q,
  input wire logic [PORT_PINS-1:0] sw_gpio_request,
  input wire logic [PORT_PINS-1:0] pin_alternate_function_select_q,
  input wire logic [IR_WIDTH-1:0] instruction_register_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // multi-cycle conditions; lengths leave room for the two-flop synchronisers
  sequence s_ext_held; (!ext_rst_n) [*5]; endsequence
  sequence s_ext_free; ext_rst_n [*8]; endsequence
  sequence s_clk_quiet; (!tck && trst_n) [*8]; endsequence
  sequence s_no_extest; (instruction_register_q != INSN_EXT_TEST) [*2]; endsequence

  a_trst_ident: assert property ($fell(trst_n) |-> ##[1:5] instruction_register_q == INSN_IDENT)
    else $error("identification not restored after test reset");
  a_pins_forced: assert property (s_ext_held |-> pin_alternate_function_select_q == PIN_AF_RESET)
    else $error("pins not in test function during external reset");
  a_pins_follow: assert property (s_ext_free |->
    pin_alternate_function_select_q == ~$past(sw_gpio_request))
    else $error("pin select does not follow the software request");
  a_rst_observed: assert property (ext_rst_n [*5] |-> core_ext_rst_n_q)
    else $error("core reset driven low while the pin is high");
  a_strobe_single: assert property (dap_wr_strobe_q |=> !dap_wr_strobe_q)
    else $error("debug write strobe longer than one cycle");
  a_strobe_code: assert property (dap_wr_strobe_q |->
    (instruction_register_q == INSN_DP_ABORT && dap_sel_q == DAP_SEL_ABORT) ||
    (instruction_register_q == INSN_DP_ACCESS && dap_sel_q == DAP_SEL_DP) ||
    (instruction_register_q == INSN_AP_ACCESS && dap_sel_q == DAP_SEL_AP))
    else $error("debug write with wrong selector or instruction");
  a_data_hold: assert property (!dap_wr_strobe_q |-> $stable(dap_wr_data_q))
    else $error("debug write data moved without a strobe");
  a_ir_quiet: assert property (s_clk_quiet |-> $stable(instruction_register_q))
    else $error("instruction changed without a test clock");
  a_pads_core: assert property (s_no_extest |->
    pad_out_q == $past(core_pad_out) && pad_oe_q == $past(core_pad_oe))
    else $error("pads not driven by the core outside external test");
endmodule : tap_instruction_decoder_asserts

bind tap_instruction_decoder tap_instruction_decoder_asserts tap_instruction_decoder_asserts_inst (
  .ref_clk, .sys_rst, .tck, .trst_n, .ext_rst_n, .core_ext_rst_n_q, .core_pad_out,
  .core_pad_oe, .pad_out_q, .pad_oe_q, .dap_wr_data_q, .dap_sel_q, .dap_wr_strobe_q,
  .sw_gpio_request, .pin_alternate_function_select_q, .instruction_register_q);

// file: tap_instruction_decoder_test.sv
// self-checking bench of the test access port instruction decoder
`timescale 1ns/1ps
module tap_instruction_decoder_test;
  import tap_decoder_pkg::*;
  localparam logic [63:0] M40 = 64'h0000_00FF_FFFF_FFFF;
  logic ref_clk, sys_rst, tck, tms, tdi, trst_n, tdo_q, tdo_oe_q;
  logic ext_rst_n, core_ext_rst_n_q, dap_wr_strobe_q;
  logic [7:0] pad_in, pad_out_q, pad_oe_q, core_pad_out, core_pad_oe, core_pad_in_q;
  logic [7:0] eo, ee, ei;
  logic [34:0] dap_capture_data, dap_wr_data_q;
  logic [1:0] dap_sel_q;
  logic [4:0] sw_gpio_request, pin_alternate_function_select_q;
  logic [3:0] instruction_register_q;
  logic [31:0] lfsr_q = 32'h9F3CC9E8;
  logic [63:0] din, dout, cap;
  int failures = 0;
  int cmp_count = 0;
  int len, sh;

  tap_instruction_decoder tap_instruction_decoder_inst (
    .ref_clk, .sys_rst, .tck, .tms, .tdi, .trst_n, .tdo_q, .tdo_oe_q, .ext_rst_n,
    .core_ext_rst_n_q, .pad_in, .pad_out_q, .pad_oe_q, .core_pad_out, .core_pad_oe,
    .core_pad_in_q, .dap_capture_data, .dap_wr_data_q, .dap_sel_q, .dap_wr_strobe_q,
    .sw_gpio_request, .pin_alternate_function_select_q, .instruction_register_q);
  tap_probe_model tap_probe_model_inst (.ref_clk, .tck, .tms, .tdi, .tdo(tdo_q));

  // 125 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic rnd(output logic [63:0] r);
    lfsr_q = lfsr_next(lfsr_q);
    r[31:0] = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    r[63:32] = lfsr_q;
  endtask : rnd

  // reference chain: captured bits come out first, then the bits shifted in
  function automatic logic [63:0] predict(input logic [63:0] c, input int l,
                                          input logic [63:0] d);
    logic [63:0] r;
    for (int i = 0; i < 64; i++) r[i] = (i < l) ? c[i] : d[i - l];
    return r;
  endfunction : predict

  // chain length and capture value expected for an instruction code
  task automatic model(input logic [3:0] c, output int l, output logic [63:0] cp);
    cp = '0;
    l = 1; // bypass and all unassigned codes capture a single zero
    if (c == INSN_IDENT) begin
      l = 32;
      cp = 64'(IDENT_VALUE);
    end
    if (c == INSN_DP_ABORT || c == INSN_DP_ACCESS || c == INSN_AP_ACCESS) begin
      l = 35;
      cp = 64'(dap_capture_data);
    end
    if (c <= INSN_SAMPLE_PRELOAD) begin
      l = 25;
      for (int p = 0; p < 8; p++) cp[3*p +: 3] = {core_pad_oe[p], core_pad_out[p], pad_in[p]};
      cp[24] = ext_rst_n;
    end
  endtask : model

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic load_ir(input logic [3:0] c);
    tap_probe_model_inst.scan(1'b1, 4, 64'(c), dout);
  endtask : load_ir

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // main sequence; inputs change only at falling edges
  initial begin
    sys_rst = 1'b1;
    trst_n = 1'b1;
    ext_rst_n = 1'b1;
    sw_gpio_request = 5'h00; // test pins left in test function
    {pad_in, core_pad_out, core_pad_oe} = 24'h5A3CF0;
    dap_capture_data = '0;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(pin_alternate_function_select_q, PIN_AF_RESET, "pin default");
    check(instruction_register_q, INSN_IDENT, "reset insn");
    repeat (6) @(negedge ref_clk);
    tap_probe_model_inst.to_idle();
    rnd(din);
    tap_probe_model_inst.scan(1'b0, 40, din, dout);
    check(dout & M40, predict(IDENT_VALUE, 32, din) & M40, "ident");
    $display("identification test done");
    // every code, with fresh pad and debug capture values each time
    for (int c = 0; c < 16; c++) begin
      rnd(din);
      {dap_capture_data, core_pad_oe, core_pad_out, pad_in} = din[58:0];
      load_ir(c[3:0]);
      check(dout[3:0], IR_CAPTURE_PATTERN, "ir capture");
      check(instruction_register_q, c[3:0], "active insn");
      model(c[3:0], len, cap);
      rnd(din);
      tap_probe_model_inst.scan(1'b0, 40, din, dout);
      sh = (c < 2) ? 25 : 0; // pads under test hold preload, only length is known
      check((dout & M40) >> sh, (predict(cap, len, din) & M40) >> sh, "chain");
      if (len == 35) begin
        check(dap_wr_data_q, din[39:5], "debug write");
        check(dap_sel_q, (c == 10) ? 2'h1 : (c == 11) ? 2'h2 : 2'h0, "debug sel");
      end
      $display("code %h test done", c[3:0]);
    end
    check(tdo_oe_q, 1'b0, "tdo idle");
    // preload, then drive it onto the pads and into the core
    rnd(din);
    din[24] = 1'b0; // reset cell loaded low must never reach the core
    load_ir(INSN_SAMPLE_PRELOAD);
    tap_probe_model_inst.scan(1'b0, 25, din, dout);
    for (int p = 0; p < 8; p++) {ee[p], eo[p], ei[p]} = din[3*p +: 3];
    load_ir(INSN_EXT_TEST);
    check(pad_out_q, eo, "extest out");
    check(pad_oe_q, ee, "extest oe");
    load_ir(INSN_INT_TEST);
    check(core_pad_in_q, ei, "intest in");
    check(core_ext_rst_n_q, 1'b1, "reset cell");
    $display("boundary test done");
    // test reset pin and tms-driven reset both restore identification
    load_ir(INSN_BYPASS);
    trst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(instruction_register_q, INSN_IDENT, "trst insn");
    trst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    tap_probe_model_inst.to_idle();
    load_ir(INSN_BYPASS);
    tap_probe_model_inst.to_idle();
    check(instruction_register_q, INSN_IDENT, "tms reset insn");
    $display("reset test done");
    // software pin requests, overridden by the external reset
    sw_gpio_request = din[36:32] | 5'h01;
    repeat (3) @(negedge ref_clk);
    check(pin_alternate_function_select_q, 5'(~sw_gpio_request), "pin follow");
    ext_rst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(pin_alternate_function_select_q, PIN_AF_RESET, "pin forced");
    ext_rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(pin_alternate_function_select_q, 5'(~sw_gpio_request), "pin release");
    $display("pin select test done");
    wrap_up();
  end
endmodule : tap_instruction_decoder_test

// file: tap_probe_model.sv
// debug probe model that clocks the test port and reads serial data back
`timescale 1ns/1ps
module tap_probe_model (
  // pacing clock
  input wire logic ref_clk,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // test clock rests low between scans, as a real probe would
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test-clock period: 10 system cycles low, then 10 high
  task automatic clk_bit(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (10) @(negedge ref_clk);
    q = tdo; // read just before the rise, long after the last fall
    tck = 1'b1;
    repeat (10) @(negedge ref_clk);
    tck = 1'b0;
  endtask : clk_bit

  // five highs reach test-logic-reset from any state, then settle in idle
  task automatic to_idle();
    logic q;
    repeat (5) clk_bit(1'b1, ~tdi, q);
    clk_bit(1'b0, ~tdi, q);
  endtask : to_idle

  // full scan from idle back to idle, least significant bit first
  task automatic scan(input logic ir, input int len, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    clk_bit(1'b1, ~tdi, q);
    if (ir) begin
      clk_bit(1'b1, ~tdi, q);
    end
    clk_bit(1'b0, ~tdi, q);
    clk_bit(1'b0, ~tdi, q);
    for (int i = 0; i < len; i++) begin
      clk_bit(i == len - 1, din[i], q); // last bit leaves through exit1
      dout[i] = q;
    end
    clk_bit(1'b1, ~tdi, q); // unused data line toggles outside shifting
    clk_bit(1'b0, ~tdi, q);
  endtask : scan
endmodule : tap_probe_model

// file: tap_state_tracker.sv
// test access port controller state machine, advanced on each test-clock rise
`timescale 1ns/1ps
module tap_state_tracker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // synchronised link signals
  input wire logic tck_rise,
  input wire logic tms,
  input wire logic trst,
  // current state
  output tap_decoder_pkg::tap_state_type state_q
);
  import tap_decoder_pkg::*;

  tap_state_type state_d;

  // standard sixteen-state walk steered by the mode select line
  always_comb begin
    state_d = state_q;
    if (tck_rise) begin
      case (state_q)
        TAP_RESET:      state_d = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:       state_d = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:     state_d = tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
        TAP_CAPTURE_DR: state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR:   state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR:   state_d = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR:   state_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR:   state_d = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
        TAP_UPDATE_DR:  state_d = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:     state_d = tms ? TAP_RESET : TAP_CAPTURE_IR;
        TAP_CAPTURE_IR: state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR:   state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR:   state_d = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR:   state_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR:   state_d = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
        TAP_UPDATE_IR:  state_d = tms ? TAP_SEL_DR : TAP_IDLE;
        default:        state_d = TAP_RESET;
      endcase
    end
  end

  // test reset pin forces the reset state without waiting for a clock rise
  always_ff @(posedge ref_clk) begin
    if (sys_rst || trst) begin
      state_q <= TAP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

endmodule : tap_state_tracker
